// ==== design/ddr_native_defs.svh ====
// Constants for the native request port
`ifndef DDR_NATIVE_DEFS_SVH
`define DDR_NATIVE_DEFS_SVH

// Least spacing, in clocks, between two memory commands
`define CMD_SPACING 4
`define CMD_GAP_W 2
`define CMD_GAP_RELOAD 2'h3
`define CMD_GAP_ZERO 2'h0

// Buffer shape
`define RDBUF_DEPTH 2
`define RDBUF_CNT_W 2

// Beat count reset value and last-beat threshold
`define BEATS_RESET 6'h00
`define BEAT_ONE 6'h01

`endif

// ==== design/ddr_native_pkg.sv ====
// Types for the native request port
package ddr_native_pkg;

    typedef enum logic [6:0]
    {
        ST_IDLE   = 7'h01,
        ST_PRE    = 7'h02,
        ST_ACT    = 7'h04,
        ST_PULL   = 7'h08,
        ST_LOAD   = 7'h10,
        ST_COL    = 7'h20,
        ST_RDWAIT = 7'h40
    } state_t;

    typedef enum logic [2:0]
    {
        CMD_NOP = 3'h0,
        CMD_ACT = 3'h1,
        CMD_PRE = 3'h2,
        CMD_RD  = 3'h3,
        CMD_RDA = 3'h4,
        CMD_WR  = 3'h5,
        CMD_WRA = 3'h6
    } mem_cmd_t;

endpackage

// ==== design/two_entry_buffer.sv ====
// Two-entry valid/ready buffer
`timescale 1ns/1ps
`include "ddr_native_defs.svh"

module two_entry_buffer #(
    parameter int WIDTH = 128
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clkEn,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);

    logic [WIDTH-1:0] mem_reg [`RDBUF_DEPTH];
    logic wrPtr_reg;
    logic rdPtr_reg;
    logic [`RDBUF_CNT_W-1:0] count_reg;
    logic push;
    logic pop;

    assign inReady = (count_reg != 2'(`RDBUF_DEPTH));
    assign outValid = (count_reg != 2'h0);
    assign outData = mem_reg[rdPtr_reg];
    assign push = inValid && inReady;
    assign pop = outValid && outReady;

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            mem_reg[0] <= '0;
            mem_reg[1] <= '0;
        end
        else if (clkEn && push)
        begin
            mem_reg[wrPtr_reg] <= inData;
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            wrPtr_reg <= 1'b0;
            rdPtr_reg <= 1'b0;
            count_reg <= 2'h0;
        end
        else if (clkEn)
        begin
            if (push)
            begin
                wrPtr_reg <= ~wrPtr_reg;
            end
            if (pop)
            begin
                rdPtr_reg <= ~rdPtr_reg;
            end
            if (push && !pop)
            begin
                count_reg <= count_reg + 2'h1;
            end
            else if (pop && !push)
            begin
                count_reg <= count_reg - 2'h1;
            end
        end
    end

endmodule

// ==== design/ddr_native_request_port.sv ====
// Native user request port with bank tracking and command issue
// Summary of operation
// - A write is taken in any cycle with write request high and busy low.
// - Holding write request high yields another write each non-busy cycle.
// - Address, burst length and precharge flag sampled only while busy is low.
// - Data pull rises one cycle before write data is sampled.
// - Byte mask travels with write data; masked bytes are not written.
// - Latencies vary with bank state, refresh and configuration.
// - A read is taken in any cycle with read request high, write request low and busy low.
// - Holding read request high with write request low yields another read each non-busy cycle.
// - Read valid is high exactly while read data output holds a word.
// - Precharge flag turns the last column command of the access into its auto-precharge variant.
// - Activate row first; precharge or activate when bank or row differs.
// - Memory commands issue at most once every four clocks.
`timescale 1ns/1ps
`include "ddr_native_defs.svh"

module ddr_native_request_port #(
    parameter int DATA_W = 128,
    parameter int COL_W = 10,
    parameter int BANK_W = 3,
    parameter int ROW_W = 16,
    parameter int BSIZE_W = 6,
    parameter int ADDR_W = COL_W + BANK_W + ROW_W
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clkEn,
    input wire logic wrReq,
    input wire logic rdReq,
    input wire logic [ADDR_W-1:0] reqAddr,
    input wire logic [BSIZE_W-1:0] burstSize,
    input wire logic auto_precharge_flag,
    output logic busy,
    output logic dataPull,
    input wire logic [DATA_W-1:0] writeData,
    input wire logic [DATA_W/8-1:0] write_byte_mask,
    output logic readValid,
    input wire logic readReady,
    output logic [DATA_W-1:0] readData,
    output ddr_native_pkg::mem_cmd_t memCmd,
    output logic [BANK_W-1:0] memBank,
    output logic [ROW_W-1:0] memRow,
    output logic [COL_W-1:0] memCol,
    output logic [DATA_W-1:0] memWrData,
    output logic [DATA_W/8-1:0] memWrMask,
    input wire logic memRdValid,
    input wire logic [DATA_W-1:0] memRdData
);

    localparam int BANKS = 1 << BANK_W;

    // ************************************************************
    // Request context and bank table
    // ************************************************************
    ddr_native_pkg::state_t state_reg;
    logic isWrite_reg;
    logic autoPre_reg;
    logic [BANK_W-1:0] bank_reg;
    logic [ROW_W-1:0] row_reg;
    logic [COL_W-1:0] col_reg;
    logic [BSIZE_W-1:0] beats_reg;
    logic [BANKS-1:0] openValid_reg;
    logic [ROW_W-1:0] openRow_reg [BANKS];
    logic [`CMD_GAP_W-1:0] gap_reg;
    logic accept;
    logic cmdOk;
    logic issuePre;
    logic issueAct;
    logic issueCol;
    logic lastBeat;
    logic bufInReady;
    logic [BANK_W-1:0] reqBank;
    logic [ROW_W-1:0] reqRow;

    // Next state from the bank table: open and hit goes straight to data
    function automatic ddr_native_pkg::state_t route(input logic open, input logic hit,
        input logic wr);
        if (open && hit)
        begin
            route = wr ? ddr_native_pkg::ST_PULL : ddr_native_pkg::ST_COL;
        end
        else if (open)
        begin
            route = ddr_native_pkg::ST_PRE;
        end
        else
        begin
            route = ddr_native_pkg::ST_ACT;
        end
    endfunction

    assign reqBank = reqAddr[COL_W +: BANK_W];
    assign reqRow = reqAddr[COL_W+BANK_W +: ROW_W];

    // Only the idle state listens to requests
    assign busy = (state_reg != ddr_native_pkg::ST_IDLE);
    assign accept = !busy && (wrReq || rdReq);
    assign dataPull = (state_reg == ddr_native_pkg::ST_PULL);
    assign cmdOk = (gap_reg == `CMD_GAP_ZERO);
    assign lastBeat = (beats_reg <= `BEAT_ONE);

    // Reads wait for buffer room so a returning word always has a slot
    always_comb
    begin
        issuePre = cmdOk && (state_reg == ddr_native_pkg::ST_PRE);
        issueAct = cmdOk && (state_reg == ddr_native_pkg::ST_ACT);
        issueCol = cmdOk && (state_reg == ddr_native_pkg::ST_COL)
            && (isWrite_reg || bufInReady);
    end

    // ************************************************************
    // Sequencer
    // ************************************************************
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            state_reg <= ddr_native_pkg::ST_IDLE;
        else if (clkEn)
        begin
            case (state_reg)
                ddr_native_pkg::ST_IDLE:
                    if (accept)
                        state_reg <= route(openValid_reg[reqBank],
                            openRow_reg[reqBank] == reqRow, wrReq);
                ddr_native_pkg::ST_PRE:
                    if (issuePre)
                        state_reg <= ddr_native_pkg::ST_ACT;
                ddr_native_pkg::ST_ACT:
                    if (issueAct)
                        state_reg <= route(1'b1, 1'b1, isWrite_reg);
                ddr_native_pkg::ST_PULL:
                    state_reg <= ddr_native_pkg::ST_LOAD;
                ddr_native_pkg::ST_LOAD:
                    state_reg <= ddr_native_pkg::ST_COL;
                ddr_native_pkg::ST_COL:
                    if (issueCol && !isWrite_reg)
                        state_reg <= ddr_native_pkg::ST_RDWAIT;
                    else if (issueCol)
                        state_reg <= lastBeat ? ddr_native_pkg::ST_IDLE : ddr_native_pkg::ST_PULL;
                ddr_native_pkg::ST_RDWAIT:
                    if (memRdValid)
                        state_reg <= lastBeat ? ddr_native_pkg::ST_IDLE : ddr_native_pkg::ST_COL;
                default:
                    state_reg <= ddr_native_pkg::ST_IDLE;
            endcase
        end
    end

    // Fields captured only on acceptance, so they are ignored while busy
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            isWrite_reg <= 1'b0;
            autoPre_reg <= 1'b0;
            bank_reg <= '0;
            row_reg <= '0;
            col_reg <= '0;
            beats_reg <= `BEATS_RESET;
        end
        else if (clkEn)
        begin
            if (accept)
            begin
                isWrite_reg <= wrReq;
                autoPre_reg <= auto_precharge_flag;
                bank_reg <= reqBank;
                row_reg <= reqRow;
                col_reg <= reqAddr[COL_W-1:0];
                beats_reg <= burstSize;
            end
            else if ((issueCol && isWrite_reg) || (state_reg == ddr_native_pkg::ST_RDWAIT
                && memRdValid))
            begin
                col_reg <= col_reg + COL_W'(1);
                beats_reg <= beats_reg - BSIZE_W'(1);
            end
        end
    end

    // Open-row table; auto-precharge on the final beat closes the bank
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            openValid_reg <= '0;
            for (int i = 0; i < BANKS; i++)
            begin
                openRow_reg[i] <= '0;
            end
        end
        else if (clkEn)
        begin
            if (issuePre)
            begin
                openValid_reg[bank_reg] <= 1'b0;
            end
            else if (issueAct)
            begin
                openValid_reg[bank_reg] <= 1'b1;
                openRow_reg[bank_reg] <= row_reg;
            end
            else if (issueCol && lastBeat && autoPre_reg)
            begin
                openValid_reg[bank_reg] <= 1'b0;
            end
        end
    end

    // ************************************************************
    // Command issue
    // ************************************************************
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            gap_reg <= `CMD_GAP_ZERO;
        else if (clkEn && (issuePre || issueAct || issueCol))
            gap_reg <= `CMD_GAP_RELOAD;
        else if (clkEn && !cmdOk)
            gap_reg <= gap_reg - `CMD_GAP_W'(1);
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            memCmd <= ddr_native_pkg::CMD_NOP;
            memBank <= '0;
            memRow <= '0;
            memCol <= '0;
        end
        else if (clkEn)
        begin
            memBank <= bank_reg;
            memRow <= row_reg;
            memCol <= col_reg;
            if (issuePre)
                memCmd <= ddr_native_pkg::CMD_PRE;
            else if (issueAct)
                memCmd <= ddr_native_pkg::CMD_ACT;
            else if (issueCol && isWrite_reg)
            begin
                memCmd <= (autoPre_reg && lastBeat) ? ddr_native_pkg::CMD_WRA
                    : ddr_native_pkg::CMD_WR;
            end
            else if (issueCol)
            begin
                memCmd <= (autoPre_reg && lastBeat) ? ddr_native_pkg::CMD_RDA
                    : ddr_native_pkg::CMD_RD;
            end
            else
                memCmd <= ddr_native_pkg::CMD_NOP;
        end
    end

    // Write word sampled the cycle after the pull, mask kept beside it
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            memWrData <= '0;
            memWrMask <= '0;
        end
        else if (clkEn && state_reg == ddr_native_pkg::ST_LOAD)
        begin
            memWrData <= writeData;
            memWrMask <= write_byte_mask;
        end
    end

    // ************************************************************
    // Read return path
    // ************************************************************
    two_entry_buffer #(
        .WIDTH(DATA_W)
    ) readBuf (
        .sys_clk(sys_clk),
        .rst(rst),
        .clkEn(clkEn),
        .inValid(memRdValid && state_reg == ddr_native_pkg::ST_RDWAIT),
        .inReady(bufInReady),
        .inData(memRdData),
        .outValid(readValid),
        .outReady(readReady),
        .outData(readData)
    );

endmodule

// ==== verification/ddr_port_checker.sv ====
// Concurrent checks on the native request port
`timescale 1ns/1ps

module ddr_port_checker #(
    parameter int DATA_W = 128
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic wrReq,
    input wire logic rdReq,
    input wire logic auto_precharge_flag,
    input wire logic busy,
    input wire logic dataPull,
    input wire logic readValid,
    input wire logic readReady,
    input wire logic [DATA_W-1:0] readData,
    input wire ddr_native_pkg::mem_cmd_t memCmd,
    input wire logic memRdValid
);
    // ****************
    // Port properties
    // ****************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    chk_take_busy: assert property ((wrReq || rdReq) && !busy |=> busy)
        else $error("busy did not follow an accepted request");
    chk_cmd_spacing: assert property (memCmd != ddr_native_pkg::CMD_NOP |=>
        memCmd == ddr_native_pkg::CMD_NOP [*3])
        else $error("memory commands closer than four clocks");
    chk_pull_pulse: assert property (dataPull |-> busy ##1 !dataPull)
        else $error("data pull not a single pulse inside a transfer");
    chk_read_hold: assert property (readValid && !readReady |=>
        readValid && $stable(readData))
        else $error("read word dropped or changed while stalled");
    chk_read_push: assert property (memRdValid && busy |=> readValid)
        else $error("returned word not presented");
    chk_wra_issue: assert property (wrReq && !busy && auto_precharge_flag |->
        ##[2:80] memCmd == ddr_native_pkg::CMD_WRA)
        else $error("write with precharge flag never issued as WRA");
    chk_rda_issue: assert property (rdReq && !wrReq && !busy && auto_precharge_flag |->
        ##[2:80] memCmd == ddr_native_pkg::CMD_RDA)
        else $error("read with precharge flag never issued as RDA");
    chk_col_busy: assert property (memCmd inside {ddr_native_pkg::CMD_RD,
        ddr_native_pkg::CMD_RDA, ddr_native_pkg::CMD_WR, ddr_native_pkg::CMD_WRA}
        |-> $past(busy))
        else $error("column command outside a transfer");
endmodule

bind ddr_native_request_port ddr_port_checker #(.DATA_W(DATA_W)) i_chk (
    .sys_clk(sys_clk), .rst(rst), .wrReq(wrReq), .rdReq(rdReq),
    .auto_precharge_flag(auto_precharge_flag), .busy(busy), .dataPull(dataPull),
    .readValid(readValid), .readReady(readReady), .readData(readData),
    .memCmd(memCmd), .memRdValid(memRdValid));

// ==== verification/mem_partner.sv ====
// Behavioural memory array behind the port
`timescale 1ns/1ps

module mem_partner (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [3:0] rdLat,
    input wire ddr_native_pkg::mem_cmd_t memCmd,
    input wire logic [2:0] memBank,
    input wire logic [15:0] memRow,
    input wire logic [9:0] memCol,
    input wire logic [127:0] memWrData,
    input wire logic [15:0] memWrMask,
    output logic memRdValid,
    output logic [127:0] memRdData,
    output logic [7:0] protErr,
    output logic [7:0] autoCnt
);
    // ****************
    // Array and banks
    // ****************
    logic [127:0] store [logic [28:0]];
    logic [16:0] openRow [8];
    logic [28:0] key, rdKey;
    logic [127:0] word;
    logic [3:0] cnt;
    assign key = {memRow, memBank, memCol};

    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            memRdValid <= 1'b0;
            memRdData <= 128'h0;
            cnt <= 4'h0;
            protErr <= 8'h00;
            autoCnt <= 8'h00;
            foreach (openRow[i]) openRow[i] <= 17'h00000;
        end
        else
        begin
            memRdValid <= 1'b0;
            // Idle bus toggles so stale data never looks valid
            memRdData <= ~memRdData;
            if (cnt != 4'h0) cnt <= cnt - 4'h1;
            if (cnt == 4'h1)
            begin
                memRdValid <= 1'b1;
                memRdData <= store.exists(rdKey) ? store[rdKey] : 128'h0;
            end
            case (memCmd)
                ddr_native_pkg::CMD_ACT:
                begin
                    if (openRow[memBank][16]) protErr <= protErr + 8'h01;
                    openRow[memBank] <= {1'b1, memRow};
                end
                ddr_native_pkg::CMD_PRE: openRow[memBank] <= 17'h00000;
                ddr_native_pkg::CMD_NOP: ;
                default:
                begin
                    if (openRow[memBank] != {1'b1, memRow}) protErr <= protErr + 8'h01;
                    if (memCmd inside {ddr_native_pkg::CMD_RDA, ddr_native_pkg::CMD_WRA})
                    begin
                        autoCnt <= autoCnt + 8'h01;
                        openRow[memBank] <= 17'h00000;
                    end
                    if (memCmd inside {ddr_native_pkg::CMD_RD, ddr_native_pkg::CMD_RDA})
                    begin
                        rdKey <= key;
                        cnt <= (rdLat == 4'h0) ? 4'h1 : rdLat;
                    end
                    else
                    begin
                        word = store.exists(key) ? store[key] : 128'h0;
                        for (int j = 0; j < 16; j++)
                            if (!memWrMask[j]) word[8*j +: 8] = memWrData[8*j +: 8];
                        store[key] = word;
                    end
                end
            endcase
        end
    end
endmodule

// ==== verification/tb_ddr_native_request_port.sv ====
// Self-checking bench for the native request port
`timescale 1ns/1ps

module tb_ddr_native_request_port;
    // ****************
    // Signals and queues
    // ****************
    logic sys_clk, rst, clkEn, wrReq, rdReq, auto_precharge_flag, busy, dataPull;
    logic readValid, readReady, memRdValid, stall;
    logic [28:0] reqAddr;
    logic [5:0] burstSize;
    logic [127:0] writeData, readData, memWrData, memRdData;
    logic [15:0] write_byte_mask, memWrMask, memRow;
    logic [2:0] memBank;
    logic [9:0] memCol;
    logic [3:0] rdLat;
    logic [7:0] protErr, autoCnt;
    ddr_native_pkg::mem_cmd_t memCmd;
    logic [127:0] ex [logic [28:0]];
    logic [127:0] wq[$], xq[$], rq[$];
    logic [15:0] mq[$];
    int n_mismatch = 0;
    int compares = 0;
    int cyc = 0;

    ddr_native_request_port i_dut (.sys_clk(sys_clk), .rst(rst), .clkEn(clkEn),
        .wrReq(wrReq), .rdReq(rdReq), .reqAddr(reqAddr), .burstSize(burstSize),
        .auto_precharge_flag(auto_precharge_flag), .busy(busy), .dataPull(dataPull),
        .writeData(writeData), .write_byte_mask(write_byte_mask), .readValid(readValid),
        .readReady(readReady), .readData(readData), .memCmd(memCmd), .memBank(memBank),
        .memRow(memRow), .memCol(memCol), .memWrData(memWrData), .memWrMask(memWrMask),
        .memRdValid(memRdValid), .memRdData(memRdData));
    mem_partner i_mem (.sys_clk(sys_clk), .rst(rst), .rdLat(rdLat), .memCmd(memCmd),
        .memBank(memBank), .memRow(memRow), .memCol(memCol), .memWrData(memWrData),
        .memWrMask(memWrMask), .memRdValid(memRdValid), .memRdData(memRdData),
        .protErr(protErr), .autoCnt(autoCnt));

    initial
    begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    // Data supplier, read sink and watchdog
    always @(posedge sys_clk)
    begin
        if (dataPull === 1'b1 && wq.size() > 0)
        begin
            writeData <= wq.pop_front();
            write_byte_mask <= mq.pop_front();
        end
        if (readValid === 1'b1 && readReady === 1'b1) rq.push_back(readData);
        readReady <= stall ? !readReady : 1'b1;
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    task automatic chk(input string what, input logic [127:0] seen, input logic [127:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("BAD %s exp %h seen %h", what, exp, seen);
        end
    endtask

    task automatic issue(input logic w, input logic [28:0] a, input logic [5:0] b,
        input logic ap);
        int n;
        n = 0;
        wrReq <= w;
        rdReq <= !w;
        reqAddr <= a;
        burstSize <= b;
        auto_precharge_flag <= ap;
        // Busy judged at the falling edge, settled; fields held until the accepting edge
        @(negedge sys_clk);
        while (busy !== 1'b0 && n < 500)
        begin
            @(negedge sys_clk);
            n++;
        end
        @(posedge sys_clk);
        chk("accept wait", 128'(n >= 500), 128'h0);
    endtask

    task automatic wr(input logic [28:0] a, input logic [5:0] b, input logic [15:0] m,
        input logic ap, input logic [7:0] s);
        logic [127:0] d, o;
        for (int i = 0; i < ((b == 6'h00) ? 1 : b); i++)
        begin
            d = {4{3'h0, a + 29'(i)}} ^ {16{s}};
            o = ex.exists(a + 29'(i)) ? ex[a + 29'(i)] : 128'h0;
            for (int j = 0; j < 16; j++)
                if (!m[j]) o[8*j +: 8] = d[8*j +: 8];
            ex[a + 29'(i)] = o;
            wq.push_back(d);
            mq.push_back(m);
        end
        issue(1'b1, a, b, ap);
    endtask

    task automatic rd(input logic [28:0] a, input logic [5:0] b, input logic ap);
        for (int i = 0; i < ((b == 6'h00) ? 1 : b); i++)
            xq.push_back(ex.exists(a + 29'(i)) ? ex[a + 29'(i)] : 128'h0);
        issue(1'b0, a, b, ap);
    endtask

    task automatic drain(input string name);
        int n;
        n = 0;
        wrReq <= 1'b0;
        rdReq <= 1'b0;
        // Junk fields after acceptance must not leak in
        reqAddr <= 29'h1fffffff;
        burstSize <= 6'h3f;
        @(negedge sys_clk);
        while ((rq.size() < xq.size() || busy !== 1'b0) && n < 3000)
        begin
            @(negedge sys_clk);
            n++;
        end
        chk("drain wait", 128'(n >= 3000), 128'h0);
        chk("read count", 128'(rq.size()), 128'(xq.size()));
        chk("unpulled data", 128'(wq.size()), 128'h0);
        while (xq.size() > 0 && rq.size() > 0)
            chk("read word", rq.pop_front(), xq.pop_front());
        chk("bank order", 128'(protErr), 128'h0);
        xq.delete();
        rq.delete();
        @(posedge sys_clk);
        $display("done %s", name);
    endtask

    task automatic t_mask;
        wr(29'h0000400, 6'h02, 16'h0000, 1'b0, 8'h11);
        wr(29'h0000400, 6'h02, 16'h00ff, 1'b0, 8'h5a);
        rd(29'h0000400, 6'h02, 1'b0);
        drain("mask");
    endtask

    task automatic t_stall;
        stall <= 1'b1;
        rdLat <= 4'h6;
        wr({16'h0012, 3'h2, 10'h010}, 6'h04, 16'hf00f, 1'b0, 8'h33);
        wr({16'h0777, 3'h2, 10'h020}, 6'h00, 16'h0000, 1'b0, 8'hc3);
        rd({16'h0012, 3'h2, 10'h010}, 6'h04, 1'b0);
        rd({16'h0777, 3'h2, 10'h020}, 6'h01, 1'b0);
        drain("stall");
        stall <= 1'b0;
        rdLat <= 4'h1;
    endtask

    task automatic t_auto;
        logic [7:0] a0;
        a0 = autoCnt;
        wr({16'h0100, 3'h5, 10'h3fe}, 6'h01, 16'h0000, 1'b1, 8'h96);
        rd({16'h0100, 3'h5, 10'h3fe}, 6'h01, 1'b1);
        drain("auto");
        chk("auto count", 128'(autoCnt), 128'(a0 + 8'h02));
    endtask

    task automatic tally_and_finish;
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial
    begin
        rst = 1'b1;
        clkEn = 1'b1;
        wrReq = 1'b0;
        rdReq = 1'b0;
        reqAddr = 29'h0;
        burstSize = 6'h01;
        auto_precharge_flag = 1'b0;
        writeData = 128'h0;
        write_byte_mask = 16'h0;
        readReady = 1'b1;
        stall = 1'b0;
        rdLat = 4'h1;
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        t_mask();
        t_stall();
        t_auto();
        tally_and_finish();
    end
endmodule
